// file: pkg/cbt_pkg.sv
/*
 * Constants for the command bus training block of a low-power DRAM die.
 * Assumes a 200 MHz core clock and mode register writes already decoded.
 */
package cbt_pkg;
	// ==========================================================
	// timing
	localparam int MCLK_PERIOD_PS  = 5000;
	localparam int ENTRY_DELAY_NS  = 250;
	localparam int ENTRY_DELAY_CYC =
		(ENTRY_DELAY_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
	// ==========================================================
	// mode register addresses and fields
	localparam logic [5:0] ADDR_INFO     = 6'h00;
	localparam logic [5:0] ADDR_CAREF    = 6'h0C;
	localparam logic [5:0] ADDR_SETPOINT = 6'h0D;
	localparam int SP_TRAIN_BIT = 0;
	localparam int SP_WRSEL_BIT = 6;
	localparam int SP_OPSEL_BIT = 7;
	localparam int INFO_TERM_BIT = 7;
	localparam int VREF_RANGE_BIT = 6;
	// ==========================================================
	// reset values
	localparam logic [7:0] SETPOINT_RESET = 8'h00;
	localparam logic [6:0] CAREF_RESET    = 7'h1D;
	// ==========================================================
	// training sequence states
	typedef enum logic [1:0] {
		CBT_IDLE   = 2'b00,
		CBT_ARMED  = 2'b01,
		CBT_TRAIN  = 2'b10,
		CBT_EXITED = 2'b11
	} cbt_state_t;
endpackage

// file: core/cbt_core.sv
/*
 * Command bus training logic of the DRAM die: set-point switching,
 * reference capture from strobe 0 and CA feedback onto the upper DQ lanes.
 * Assumes an upstream decoder presents mode register writes on mclk and
 * that CK from the controller keeps running while clock enable is low.
 */
`timescale 1ns/10ps
`default_nettype none
module cbt_core #(
	parameter int ENTRY_CYC = cbt_pkg::ENTRY_DELAY_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       ck,
	input  wire logic       mrwValid,
	input  wire logic [5:0] mrwAddr,
	input  wire logic [7:0] mrwData,
	input  wire logic [5:0] rdAddr,
	output logic      [7:0] rdData,
	input  wire logic       cke,
	input  wire logic       cs,
	input  wire logic [5:0] ca,
	input  wire logic       dqsT,
	input  wire logic [6:0] dqIn,
	input  wire logic       termPad,
	output logic [5:0]      caFeedback,
	output logic            caFeedbackOe,
	output logic            activeSetpoint,
	output logic            trainingActive,
	output logic [6:0]      caVref,
	output logic            vrefUpdated
);
	// ==========================================================
	// pin synchronisers
	logic       ckeMeta, ckeS;
	logic       dqsMeta, dqsS, dqsLast;
	logic [6:0] dqMeta, dqS;
	logic       termMeta, termS;
	// pins are asynchronous to mclk; first stage feeds only the second
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ckeMeta  <= 1'b0;
			ckeS     <= 1'b0;
			dqsMeta  <= 1'b0;
			dqsS     <= 1'b0;
			dqsLast  <= 1'b0;
			dqMeta   <= 7'h00;
			dqS      <= 7'h00;
			termMeta <= 1'b0;
			termS    <= 1'b0;
		end else begin
			ckeMeta  <= cke;
			ckeS     <= ckeMeta;
			dqsMeta  <= dqsT;
			dqsS     <= dqsMeta;
			dqsLast  <= dqsS;
			dqMeta   <= dqIn;
			dqS      <= dqMeta;
			termMeta <= termPad;
			termS    <= termMeta;
		end
	end

	logic dqsEdge;
	assign dqsEdge = dqsS ^ dqsLast;  // both edges of the strobe

	// ==========================================================
	// termination strap, caught once the synchroniser holds the pad;
	// taking it at the first edge would latch the reset level instead
	logic       termStrap, strapDone;
	logic [1:0] strapCnt;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			termStrap <= 1'b0;
			strapDone <= 1'b0;
			strapCnt  <= 2'h0;
		end else if (!strapDone) begin
			strapCnt <= strapCnt + 2'h1;
			if (strapCnt == 2'h2) begin
				termStrap <= termS;
				strapDone <= 1'b1;
			end
		end
	end

	// ==========================================================
	// mode registers: set-point control and two reference copies
	logic [7:0] spCtrl;
	logic [6:0] caRef0, caRef1;
	logic       opSel;
	assign opSel = spCtrl[cbt_pkg::SP_OPSEL_BIT];

	// power-up selects set zero
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			spCtrl <= cbt_pkg::SETPOINT_RESET;
		end else if (mrwValid && mrwAddr == cbt_pkg::ADDR_SETPOINT) begin
			spCtrl <= mrwData;
		end
	end

	// reference writes land in the set chosen by the write selector;
	// training results never come here on their own
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			caRef0 <= cbt_pkg::CAREF_RESET;
			caRef1 <= cbt_pkg::CAREF_RESET;
		end else if (mrwValid && mrwAddr == cbt_pkg::ADDR_CAREF) begin
			if (spCtrl[cbt_pkg::SP_WRSEL_BIT]) begin
				caRef1 <= mrwData[6:0];
			end else begin
				caRef0 <= mrwData[6:0];
			end
		end
	end

	// ==========================================================
	// training sequence
	cbt_pkg::cbt_state_t state;
	logic                trainBit;
	assign trainBit = spCtrl[cbt_pkg::SP_TRAIN_BIT];

	// arming needs clock enable high, so entry from self refresh works
	// only when the die is not powered down
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= cbt_pkg::CBT_IDLE;
		end else begin
			case (state)
				cbt_pkg::CBT_IDLE: begin
					if (trainBit && ckeS) begin
						state <= cbt_pkg::CBT_ARMED;
					end
				end
				cbt_pkg::CBT_ARMED: begin
					if (!trainBit) begin
						state <= cbt_pkg::CBT_IDLE;
					end else if (!ckeS) begin
						state <= cbt_pkg::CBT_TRAIN;
					end
				end
				cbt_pkg::CBT_TRAIN: begin
					if (ckeS) begin
						state <= cbt_pkg::CBT_EXITED;
					end
				end
				cbt_pkg::CBT_EXITED: begin
					if (!trainBit) begin
						state <= cbt_pkg::CBT_IDLE;
					end
				end
				default: begin
					state <= cbt_pkg::CBT_IDLE;
				end
			endcase
		end
	end

	logic inTrain;
	assign inTrain = (state == cbt_pkg::CBT_TRAIN);
	assign trainingActive = inTrain;
	assign caFeedbackOe   = inTrain;  // upper lanes driven only now
	// strobe pair 1, mask lane 1 and DQ[15:14] are left undriven

	// active set: alternate while training, original otherwise
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			activeSetpoint <= 1'b0;
		end else if (state == cbt_pkg::CBT_ARMED && trainBit && !ckeS) begin
			activeSetpoint <= ~opSel;
		end else if (!inTrain || ckeS) begin
			activeSetpoint <= opSel;
		end
	end

	// ==========================================================
	// entry delay before strobe updates are taken
	logic [15:0] entryCnt;
	logic        accept;
	assign accept = (entryCnt == 16'(ENTRY_CYC));
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			entryCnt <= 16'h0000;
		end else if (!inTrain) begin
			entryCnt <= 16'h0000;
		end else if (!accept) begin
			entryCnt <= entryCnt + 16'h0001;
		end
	end

	// ==========================================================
	// temporary reference captured from DQ[6:0]; DQ[7] and mask lane 0
	// have no ports, so a floating level cannot disturb anything
	logic [6:0] tempVref;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tempVref    <= cbt_pkg::CAREF_RESET;
			vrefUpdated <= 1'b0;
		end else if (state == cbt_pkg::CBT_ARMED && !ckeS) begin
			tempVref    <= opSel ? caRef0 : caRef1;
			vrefUpdated <= 1'b0;
		end else if (inTrain && accept && dqsEdge) begin
			// each edge overwrites; bit i comes from DQ i
			tempVref    <= dqS;
			vrefUpdated <= 1'b1;
		end
	end

	// reference seen by the CA receivers; range is bit 6
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			caVref <= cbt_pkg::CAREF_RESET;
		end else if (inTrain) begin
			caVref <= tempVref;
		end else begin
			caVref <= activeSetpoint ? caRef1 : caRef0;
		end
	end

	// ==========================================================
	// register read port
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdData <= 8'h00;
		end else begin
			case (rdAddr)
				cbt_pkg::ADDR_INFO: begin
					rdData <= 8'(termStrap) << cbt_pkg::INFO_TERM_BIT;
				end
				cbt_pkg::ADDR_CAREF: begin
					rdData <= {1'b0, (spCtrl[cbt_pkg::SP_WRSEL_BIT] ?
						caRef1 : caRef0)};
				end
				cbt_pkg::ADDR_SETPOINT: begin
					rdData <= spCtrl;
				end
				default: begin
					rdData <= 8'h00;
				end
			endcase
		end
	end

	// ==========================================================
	// link side: CA latch on CK, handed to mclk by req/ack toggles
	logic       ckTrainMeta, ckTrain;
	logic       ackMeta, ackS, reqTgl;
	logic       reqMeta, reqS, ackTgl;
	logic [5:0] caHold;
	logic       ckBusy;
	assign ckBusy = reqTgl ^ ackS;

	// training level crosses into CK; a new sample waits for the ack,
	// so back-to-back selects faster than the handshake are skipped
	always_ff @(posedge ck or negedge rst_b) begin
		if (!rst_b) begin
			ckTrainMeta <= 1'b0;
			ckTrain     <= 1'b0;
			ackMeta     <= 1'b0;
			ackS        <= 1'b0;
			reqTgl      <= 1'b0;
			caHold      <= 6'h00;
		end else begin
			ckTrainMeta <= inTrain;
			ckTrain     <= ckTrainMeta;
			ackMeta     <= ackTgl;
			ackS        <= ackMeta;
			if (ckTrain && cs && !ckBusy) begin
				caHold <= ca;
				reqTgl <= ~reqTgl;
			end
		end
	end

	// caHold is steady while the request is open, so it is read directly
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reqMeta    <= 1'b0;
			reqS       <= 1'b0;
			ackTgl     <= 1'b0;
			caFeedback <= 6'h00;
		end else begin
			reqMeta <= reqTgl;
			reqS    <= reqMeta;
			if (reqS != ackTgl) begin
				caFeedback <= caHold;  // CA i onto DQ 8+i
				ackTgl     <= reqS;
			end
		end
	end

	// ==========================================================
	// checks
	int unsigned quietCnt;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			quietCnt <= 0;
		end else begin
			quietCnt <= inTrain ? quietCnt + 1 : 0;
		end
	end

	a_reset_set0: assert property (@(posedge mclk)
		$rose(rst_b) |-> !activeSetpoint)
		else $error("active set not zero after reset");
	a_entry_alt: assert property (@(posedge mclk) disable iff (!rst_b)
		(state == cbt_pkg::CBT_ARMED && trainBit && !ckeS && !mrwValid)
		|=> inTrain && activeSetpoint == ~opSel)
		else $error("no switch to alternate set on entry");
	a_exit_restore: assert property (@(posedge mclk) disable iff (!rst_b)
		(inTrain && ckeS && !mrwValid) |=> activeSetpoint == opSel
		##1 caVref == (opSel ? $past(caRef1) : $past(caRef0)))
		else $error("original set not restored on exit");
	a_no_retain: assert property (@(posedge mclk) disable iff (!rst_b)
		(inTrain && !mrwValid) |=> $stable(caRef0) && $stable(caRef1))
		else $error("training value written into a set");
	a_entry_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(inTrain) |-> !accept [*8] ##[1:300] accept)
		else $error("entry delay wrong");
	a_early_stable: assert property (@(posedge mclk) disable iff (!rst_b)
		(inTrain && !accept && quietCnt > 0) |=> $stable(tempVref))
		else $error("reference changed before entry delay");
	a_dq_capture: assert property (@(posedge mclk) disable iff (!rst_b)
		(inTrain && accept && dqsEdge) |=> tempVref == $past(dqS)
		##1 (!inTrain || caVref == $past(tempVref)))
		else $error("strobe capture mismatch");
	a_info_term: assert property (@(posedge mclk) disable iff (!rst_b)
		(strapDone && rdAddr == cbt_pkg::ADDR_INFO)
		|=> rdData[cbt_pkg::INFO_TERM_BIT] == $past(termStrap))
		else $error("terminating bit wrong");
	a_ca_latch: assert property (@(posedge ck) disable iff (!rst_b)
		(ckTrain && cs && !ckBusy) |=> caHold == $past(ca) && ckBusy)
		else $error("CA not latched on select");
	a_feedback_oe: assert property (@(posedge mclk) disable iff (!rst_b)
		(inTrain && ckeS) |=> !caFeedbackOe)
		else $error("feedback enable outside training");

	c_entry: cover property (@(posedge mclk) disable iff (!rst_b)
		state == cbt_pkg::CBT_ARMED ##1 inTrain);
	c_update: cover property (@(posedge mclk) disable iff (!rst_b)
		inTrain && accept && dqsEdge);
	c_feedback: cover property (@(posedge mclk) disable iff (!rst_b)
		inTrain && reqS != ackTgl);
	c_exit: cover property (@(posedge mclk) disable iff (!rst_b)
		state == cbt_pkg::CBT_EXITED ##[1:50] state == cbt_pkg::CBT_IDLE);
endmodule
`default_nettype wire

// file: tb/cbt_ctrl_model.sv
/*
 * Memory controller model for command bus training: drives CK, CKE,
 * CS, CA and DQ[6:0] with strobe 0 into the training block.
 * Assumes the bench calls its tasks from one process, on mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module cbt_ctrl_model #(
	parameter int MRD_CYC    = 4,
	parameter int SETTLE_CYC = 10
) (
	input  wire logic       mclk,
	output logic            ck,
	output logic            cke,
	output logic            cs,
	output logic [5:0]      ca,
	output logic            dqsT,
	output logic [6:0]      dqIn
);
	// ==========================================================
	// link clock, 12 ns, phase unrelated to mclk
	initial begin
		ck = 1'b0;
		#1.3;
		forever #6 ck = ~ck;
	end
	// select idles low so command decoding stays off
	initial begin
		cke  = 1'b1;
		cs   = 1'b0;
		ca   = 6'h15;
		dqsT = 1'b0;
		dqIn = 7'h2A;
	end
	// ==========================================================
	// clock enable change, after the counted mode-write delay
	task setCke(input logic v);
		repeat (MRD_CYC) @(posedge mclk);
		cke <= v;
	endtask
	// two full strobe pulses, data held well around every edge
	task pulse(input logic [6:0] v);
		int i;
		@(posedge mclk);
		dqIn <= v;
		repeat (4) @(posedge mclk);
		for (i = 0; i < 4; i++) begin
			dqsT <= ~dqsT;
			repeat (4) @(posedge mclk);
		end
		dqIn <= ~v; // released lines show no stale value
		repeat (SETTLE_CYC) @(posedge mclk);
	endtask
	// one CA pattern, held a full CK period, then deselect
	task caSend(input logic [5:0] v, input logic sel);
		@(posedge ck);
		cs <= sel;
		ca <= v;
		@(posedge ck);
		cs <= 1'b0;
		ca <= ~v;
		repeat (4) @(posedge ck);
	endtask
endmodule
`default_nettype wire

// file: tb/tb_command_bus_training.sv
/*
 * Self-checking bench of the command bus training block.
 * Assumes the block's mode register port and the controller model.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_command_bus_training;
	logic       mclk, rst_b, mrwValid, ck, cke, cs, dqsT;
	logic [5:0] mrwAddr, rdAddr, ca, caFeedback;
	logic [7:0] mrwData, rdData;
	logic [6:0] dqIn, caVref;
	logic       caFeedbackOe, activeSetpoint, trainingActive;
	logic       vrefUpdated;
	logic       termPad;
	int         fails, compares, cyc;
	logic [6:0] vals [2] = '{7'h55, 7'h0A};

	cbt_core #(.ENTRY_CYC(40)) dut (
		.mclk(mclk), .rst_b(rst_b), .ck(ck), .mrwValid(mrwValid),
		.mrwAddr(mrwAddr), .mrwData(mrwData), .rdAddr(rdAddr),
		.rdData(rdData), .cke(cke), .cs(cs), .ca(ca), .dqsT(dqsT),
		.dqIn(dqIn), .termPad(termPad), .caFeedback(caFeedback),
		.caFeedbackOe(caFeedbackOe), .activeSetpoint(activeSetpoint),
		.trainingActive(trainingActive), .caVref(caVref),
		.vrefUpdated(vrefUpdated));
	cbt_ctrl_model ctl (
		.mclk(mclk), .ck(ck), .cke(cke), .cs(cs), .ca(ca),
		.dqsT(dqsT), .dqIn(dqIn));
	// ==========================================================
	// clock and hang guard; the run needs well under 1000 cycles
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			results;
		end
	end
	// ==========================================================
	// compare, mode register write and read
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		mrwValid <= 1'b1;
		mrwAddr  <= a;
		mrwData  <= d;
		@(posedge mclk);
		mrwValid <= 1'b0;
	endtask
	// read data is registered; looked at half a cycle after it loads
	task rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge mclk);
		rdAddr <= a;
		@(posedge mclk);
		@(negedge mclk);
		chk(rdData & m, e);
	endtask
	task results;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// main sequence: set up, enter, train, exit
	initial begin
		fails = 0; compares = 0; cyc = 0;
		mrwValid = 1'b0; mrwAddr = 6'h00; mrwData = 8'h00;
		rdAddr = 6'h00; rst_b = 1'b0;
		termPad = 1'b1;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk({7'h00, activeSetpoint}, 8'h00);
		chk({1'b0, caVref}, 8'h1D);
		chk({7'h00, caFeedbackOe}, 8'h00);
		rd(cbt_pkg::ADDR_INFO, 8'h80, 8'h80);
		wr(cbt_pkg::ADDR_SETPOINT, 8'h40);
		wr(cbt_pkg::ADDR_CAREF, 8'h2A);
		rd(cbt_pkg::ADDR_CAREF, 8'h2A, 8'h7F);
		rd(cbt_pkg::ADDR_SETPOINT, 8'h40, 8'hFF);
		wr(cbt_pkg::ADDR_SETPOINT, 8'h41);
		ctl.setCke(1'b0);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		chk({7'h00, trainingActive}, 8'h01);
		chk({7'h00, activeSetpoint}, 8'h01);
		chk({7'h00, caFeedbackOe}, 8'h01);
		chk({1'b0, caVref}, 8'h2A);
		// strobes inside the entry delay must leave the reference alone
		ctl.pulse(7'h33);
		@(negedge mclk);
		chk({1'b0, caVref}, 8'h2A);
		chk({7'h00, vrefUpdated}, 8'h00);
		repeat (40) @(posedge mclk);
		for (int i = 0; i < 2; i++) begin
			ctl.pulse(vals[i]);
			@(negedge mclk);
			chk({1'b0, caVref}, {1'b0, vals[i]});
			chk({7'h00, vrefUpdated}, 8'h01);
		end
		// selected patterns come back bit for bit, deselected ones do not
		ctl.caSend(6'h2D, 1'b1);
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		chk({2'b00, caFeedback}, 8'h2D);
		ctl.caSend(6'h12, 1'b1);
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		chk({2'b00, caFeedback}, 8'h12);
		ctl.caSend(6'h3F, 1'b0);
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		chk({2'b00, caFeedback}, 8'h12);
		ctl.setCke(1'b1);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		chk({7'h00, trainingActive}, 8'h00);
		chk({7'h00, activeSetpoint}, 8'h00);
		chk({7'h00, caFeedbackOe}, 8'h00);
		chk({1'b0, caVref}, 8'h1D);
		rd(cbt_pkg::ADDR_CAREF, 8'h2A, 8'h7F);
		wr(cbt_pkg::ADDR_SETPOINT, 8'h00);
		wr(6'h05, 8'hFF);
		rd(cbt_pkg::ADDR_SETPOINT, 8'h00, 8'hFF);
		rd(cbt_pkg::ADDR_CAREF, 8'h1D, 8'h7F);
		// second die, strapped non-terminating, trained after the first
		@(posedge mclk);
		termPad <= 1'b0;
		rst_b   <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk({7'h00, activeSetpoint}, 8'h00);
		chk({7'h00, trainingActive}, 8'h00);
		rd(cbt_pkg::ADDR_INFO, 8'h00, 8'h80);
		wr(cbt_pkg::ADDR_SETPOINT, 8'h40);
		wr(cbt_pkg::ADDR_CAREF, 8'h33);
		wr(cbt_pkg::ADDR_SETPOINT, 8'h41);
		ctl.setCke(1'b0);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		chk({7'h00, trainingActive}, 8'h01);
		chk({7'h00, activeSetpoint}, 8'h01);
		chk({1'b0, caVref}, 8'h33);
		ctl.setCke(1'b1);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		chk({7'h00, activeSetpoint}, 8'h00);
		chk({7'h00, caFeedbackOe}, 8'h00);
		chk({1'b0, caVref}, 8'h1D);
		results;
	end
endmodule
`default_nettype wire
